// ===== dv/adc_config_register_bank_assertions.sv
// Checker: port-level properties of the ADC configuration bank
`timescale 1ns/1ps
module adc_cfg_checker (
	// Clock, reset, bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [adc_cfg_pkg::ADDR_WIDTH-1:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	// Datapath and configuration
	input wire logic        data_avail_i,
	input wire logic [23:0] sample_i,
	input wire logic [31:0] sample_word_o,
	input wire logic        data_ready_out_o,
	input wire logic        data_ready_oe_n_o,
	input wire logic        reg_crc_on_o,
	input wire logic        rx_crc_on_o,
	input wire logic        crc_ansi_o,
	input wire logic        status_reset_flag_o,
	input wire logic [1:0]  word_size_select_o,
	input wire logic        timeout_on_o,
	input wire logic        chan0_on_o,
	input wire logic        chan1_on_o,
	input wire logic        chan2_on_o,
	input wire logic        chan3_on_o,
	input wire logic        ext_clock_sel_o,
	input wire logic [2:0]  oversample_ratio_o,
	input wire logic [14:0] osr_factor_o,
	input wire logic [1:0]  power_level_o,
	input wire logic [2:0]  amp_gain_c0_o,
	input wire logic [2:0]  amp_gain_c1_o,
	input wire logic [2:0]  amp_gain_c2_o,
	input wire logic [2:0]  amp_gain_c3_o
);
	import adc_cfg_pkg::*;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic        wr_hit, rd_hit, mapped;
	logic [15:0] dat_q;
	logic [23:0] smp_q;
	logic [1:0]  ws_q;
	assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_sel_i[1:0] == 2'b11);
	assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_we_i & wb_ack_o;
	assign mapped = wb_adr_i inside {8'h08, 8'h0c, 8'h10, 8'h14};
	always_ff @(posedge clk_i)
	begin
		dat_q <= wb_dat_i[15:0];
		smp_q <= sample_i;
		ws_q  <= word_size_select_o;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_map_ack; $rose(wb_stb_i) && wb_cyc_i && mapped |=> wb_ack_o && !wb_err_o; endproperty
	a_map_ack: assert property (p_map_ack) else $error("mapped access not acked");
	property p_unmapped; $rose(wb_stb_i) && wb_cyc_i && !mapped |=> wb_err_o && !wb_ack_o; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_clock; wr_hit && wb_adr_i == 8'h0c |=> {chan3_on_o, chan2_on_o, chan1_on_o, chan0_on_o,
		ext_clock_sel_o} == dat_q[11:7] && oversample_ratio_o == dat_q[4:2] && power_level_o == dat_q[1:0]
		&& osr_factor_o == (15'h0080 << dat_q[4:2]); endproperty
	a_clock: assert property (p_clock) else $error("clock fields wrong");
	property p_clock_top; rd_hit && wb_adr_i == 8'h0c |-> wb_dat_o[31:12] == 20'h0_0000; endproperty
	a_clock_top: assert property (p_clock_top) else $error("clock top bits not zero");
	property p_crc; wr_hit && wb_adr_i == 8'h08 |=> {reg_crc_on_o, rx_crc_on_o, crc_ansi_o} == dat_q[13:11];
	endproperty
	a_crc: assert property (p_crc) else $error("crc controls wrong");
	property p_size; wr_hit && wb_adr_i == 8'h08 |=> word_size_select_o == dat_q[9:8] && timeout_on_o == dat_q[4];
	endproperty
	a_size: assert property (p_size) else $error("size or timeout wrong");
	property p_rflag; wr_hit && wb_adr_i == 8'h08 |=> status_reset_flag_o == dat_q[10]; endproperty
	a_rflag: assert property (p_rflag) else $error("reset flag wrong");
	property p_gain; wr_hit && wb_adr_i == 8'h10 |=> amp_gain_c3_o == dat_q[14:12] && amp_gain_c2_o == dat_q[10:8]
		&& amp_gain_c1_o == dat_q[6:4] && amp_gain_c0_o == dat_q[2:0]; endproperty
	a_gain: assert property (p_gain) else $error("gain codes wrong");
	property p_ready; data_avail_i |=> !data_ready_oe_n_o && !data_ready_out_o; endproperty
	a_ready: assert property (p_ready) else $error("ready pin not driven low");
	property p_fmt; !wb_stb_i && word_size_select_o != WSIZE_24 |=> ((ws_q == WSIZE_16) ?
		(sample_word_o[15:0] == smp_q[23:8]) : (sample_word_o == (ws_q[0] ? {{8{smp_q[23]}}, smp_q} :
		{smp_q, 8'h00}))); endproperty
	a_fmt: assert property (p_fmt) else $error("sample format wrong");
endmodule : adc_cfg_checker

bind adc_config_register_bank adc_cfg_checker chk (.*);

// ===== dv/adc_config_register_bank_tb.sv
// Testbench: self-checking bench of the ADC configuration bank
`timescale 1ns/1ps
module adc_config_register_bank_tb;
	import adc_cfg_pkg::*;
	localparam logic [7:0]  ADR  [4] = '{8'h08, 8'h0c, 8'h10, 8'h14};
	localparam logic [15:0] RSTV [4] = '{16'h0510, 16'h0f8e, 16'h0000, 16'h0000};
	localparam logic [15:0] KEEP [4] = '{16'h3f12, 16'h0f9f, 16'h7777, 16'h0000};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc, stb, we, ack, err, dro, droe, rflag, e;
	logic        avail = 1'b0;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, sword;
	logic [23:0] samp = 24'h00_0000;
	logic [15:0] q, d;
	int          failures = 0, cmp_count = 0, cycles = 0, seed = 60, i, k;
	always #2.5 clk_i = ~clk_i;

	wb_host_model host (.clk_i(clk_i), .rst_i(rst_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack), .err_i(err));
	adc_config_register_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.data_avail_i(avail), .sample_i(samp), .sample_word_o(sword), .data_ready_out_o(dro),
		.data_ready_oe_n_o(droe), .reg_crc_on_o(), .rx_crc_on_o(), .crc_ansi_o(), .status_reset_flag_o(rflag),
		.word_size_select_o(), .timeout_on_o(), .chan0_on_o(), .chan1_on_o(), .chan2_on_o(), .chan3_on_o(),
		.ext_clock_sel_o(), .oversample_ratio_o(), .osr_factor_o(), .power_level_o(), .amp_gain_c0_o(),
		.amp_gain_c1_o(), .amp_gain_c2_o(), .amp_gain_c3_o());

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	function automatic logic [31:0] exp_word(input int c, input logic [23:0] s);
		exp_word = (c == 0) ? {16'h0000, s[23:8]} : (c == 1) ? {8'h00, s} : (c == 2) ? {s, 8'h00} :
			{{8{s[23]}}, s};
	endfunction : exp_word
	task automatic check_resets;
		for (int j = 0; j < 4; j++)
		begin
			host.xfer(1'b0, ADR[j], 16'h0000, 1'b0, q, e);
			chk(q, RSTV[j]);
		end
		chk(rflag, 1'b1);
	endtask : check_resets
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		check_resets();
		repeat (24)
		begin
			i = $unsigned($random(seed)) % 4;
			d = 16'($random(seed));
			host.xfer(1'b1, ADR[i], d, 1'b0, q, e);
			host.xfer(1'b0, ADR[i], 16'h0000, 1'b0, q, e);
			chk(q, d & KEEP[i]);
		end
		host.xfer(1'b1, 8'h0c, 16'hffff, 1'b1, q, e);
		host.xfer(1'b0, 8'h0c, 16'h0000, 1'b0, q, e);
		chk(q, 16'h0fff);
		for (k = 0; k < 4; k++)
		begin
			host.xfer(1'b1, 8'h08, {14'h0000, k[1], 1'b0}, 1'b0, q, e);
			avail <= k[0];
			repeat (3) @(posedge clk_i);
			chk({dro, droe}, {!k[0], !k[0] && k[1]});
		end
		avail <= 1'b0;
		chk(rflag, 1'b0);
		for (k = 0; k < 4; k++)
		begin
			host.xfer(1'b1, 8'h08, {6'h00, k[1:0], 8'h00}, 1'b0, q, e);
			samp <= {k[0], 23'($random(seed))};
			repeat (4) @(posedge clk_i);
			chk(sword, exp_word(k, samp));
		end
		foreach (RSTV[j])
		begin
			host.xfer(1'b0, 8'h18 - 8'(j * 5), 16'h0000, 1'b0, q, e);
			chk(e, 1'b1);
		end
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		check_resets();
		wrap_up();
	end
endmodule : adc_config_register_bank_tb

// ===== dv/wb_host_model.sv
// Host model: classic Wishbone master for the configuration bank
`timescale 1ns/1ps
module wb_host_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone master
	output logic             cyc_o = 1'b0,
	output logic             stb_o = 1'b0,
	output logic             we_o  = 1'b0,
	output logic [7:0]       adr_o = 8'h00,
	output logic [3:0]       sel_o = 4'h0,
	output logic [31:0]      dat_o = 32'h0000_0000,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i,
	input  wire logic        err_i
);
	function automatic logic [15:0] keep_mask(input logic [7:0] a);
		case (a)
			8'h08:   keep_mask = 16'h3f12;
			8'h0c:   keep_mask = 16'h0f9f;
			8'h10:   keep_mask = 16'h7777;
			default: keep_mask = 16'h0000;
		endcase
	endfunction : keep_mask

	// Raw bypasses the zero fill, for deliberate misuse only
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, input logic raw,
		output logic [15:0] q, output logic e);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= {16'h0000, raw ? d : (d & keep_mask(a))};
		// No cycle limit here; only the bench timeout ends a stuck wait
		do
		begin
			@(posedge clk_i);
		end
		while (!(ack_i | err_i));
		q = dat_i[15:0];
		e = err_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Released address and data lines carry junk so stale values are not trusted
		adr_o <= ~adr_o;
		dat_o <= ~dat_o;
	endtask : xfer
endmodule : wb_host_model

// ===== rtl/adc_cfg_pkg.sv
// Package: register map, field positions and reset values of the ADC configuration bank
package adc_cfg_pkg;

	// ----------------------------------------
	// Register indices and address width
	// ----------------------------------------
	localparam logic [3:0]  MODE_INDEX       = 4'h2;
	localparam logic [3:0]  CLOCK_INDEX      = 4'h3;
	localparam logic [3:0]  GAIN_INDEX       = 4'h4;
	localparam logic [3:0]  RSVD5_INDEX      = 4'h5;
	localparam int          ADDR_WIDTH       = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] MODE_RESET       = 16'h0510;
	localparam logic [15:0] CLOCK_RESET      = 16'h0f8e;
	localparam logic [15:0] GAIN_RESET       = 16'h0000;
	localparam logic [15:0] RSVD5_RESET      = 16'h0000;

	// ----------------------------------------
	// Mode word fields
	// ----------------------------------------
	localparam int          MODE_REG_CRC_BIT = 13;
	localparam int          MODE_RX_CRC_BIT  = 12;
	localparam int          MODE_CRC_SEL_BIT = 11;
	localparam int          MODE_RST_FLAG_BIT = 10;
	localparam int          MODE_WSIZE_LSB   = 8;
	localparam int          MODE_TIMEOUT_BIT = 4;
	localparam int          MODE_FLOAT_BIT   = 1;
	localparam logic [15:0] MODE_WRITE_MASK  = 16'h3f12;

	// ----------------------------------------
	// Clock word fields
	// ----------------------------------------
	localparam int          CLOCK_CHAN_LSB   = 8;
	localparam int          CLOCK_SRC_BIT    = 7;
	localparam int          CLOCK_OSR_LSB    = 2;
	localparam int          CLOCK_PWR_LSB    = 0;
	localparam logic [15:0] CLOCK_WRITE_MASK = 16'h0fff;

	// ----------------------------------------
	// Gain word fields
	// ----------------------------------------
	localparam int          GAIN_FIELD_STEP  = 4;
	localparam logic [15:0] GAIN_WRITE_MASK  = 16'hffff;

	// ----------------------------------------
	// Word size codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		WSIZE_16      = 2'h0,
		WSIZE_24      = 2'h1,
		WSIZE_32_PAD  = 2'h2,
		WSIZE_32_SIGN = 2'h3
	} word_size_t;

endpackage : adc_cfg_pkg

// ===== rtl/adc_config_register_bank.sv
// Module: configuration register bank of a four-channel delta-sigma ADC
//
// Summary of operation
// R1 - Mode bit 13 enables register map CRC, cleared after reset.
// R2 - Mode bit 12 enables CRC checking of received serial data, reset disabled.
// R3 - Mode bit 11 picks CRC polynomial: cleared CCITT, set ANSI, both links.
// R4 - Mode bit 10 reads one after reset; writing zero clears it and status flag.
// R5 - Mode bits 9:8 pick word length: 00 16, 01 24 (reset), 1x 32.
// R6 - Code 10 pads zeros below LSB; code 11 sign-extends the upper bits.
// R7 - Mode bit 4 enables serial timeout; set after reset.
// R8 - Mode bit 1 sets idle ready pin: cleared drives high, set floats.
// R9 - Host writes zeros to reserved fields, including all of word five.
// R10 - Clock bits 15:12 are read-only and read zero.
// R11 - Clock bits 11:8 enable channels 3 down to 0; all set after reset.
// R12 - Clock bit 7 selects clock source: internal cleared, external set (reset).
// R13 - Clock bits 4:2 set oversampling 128 to 16384; reset code 011.
// R14 - Clock bits 1:0 set power mode; 10 or 11 high resolution, reset 10.
// R15 - Gain word holds a 3-bit gain code per channel, gain two to n.
// R16 - Clock word sits at address 03h, reset 0F8Eh.
// R17 - Gain word sits at address 04h, reset 0000h.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module adc_config_register_bank (
	// Clock and reset
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	// Wishbone slave
	input  wire logic                             wb_cyc_i,
	input  wire logic                             wb_stb_i,
	input  wire logic                             wb_we_i,
	input  wire logic [adc_cfg_pkg::ADDR_WIDTH-1:0] wb_adr_i,
	input  wire logic [3:0]                       wb_sel_i,
	input  wire logic [31:0]                      wb_dat_i,
	output logic      [31:0]                      wb_dat_o,
	output logic                                  wb_ack_o,
	output logic                                  wb_err_o,
	// Conversion datapath hooks
	input  wire logic                             data_avail_i,
	input  wire logic [23:0]                      sample_i,
	output logic      [31:0]                      sample_word_o,
	output logic                                  data_ready_out_o,
	output logic                                  data_ready_oe_n_o,
	// Configuration outputs
	output logic                                  reg_crc_on_o,
	output logic                                  rx_crc_on_o,
	output logic                                  crc_ansi_o,
	output logic                                  status_reset_flag_o,
	output logic      [1:0]                       word_size_select_o,
	output logic                                  timeout_on_o,
	output logic                                  chan0_on_o,
	output logic                                  chan1_on_o,
	output logic                                  chan2_on_o,
	output logic                                  chan3_on_o,
	output logic                                  ext_clock_sel_o,
	output logic      [2:0]                       oversample_ratio_o,
	output logic      [14:0]                      osr_factor_o,
	output logic      [1:0]                       power_level_o,
	output logic      [2:0]                       amp_gain_c0_o,
	output logic      [2:0]                       amp_gain_c1_o,
	output logic      [2:0]                       amp_gain_c2_o,
	output logic      [2:0]                       amp_gain_c3_o
);

	import adc_cfg_pkg::*;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        req;
	logic        wr_req;
	logic [5:0]  word_idx;
	logic        aligned;
	logic        hit_mode;
	logic        hit_clock;
	logic        hit_gain;
	logic        hit_rsvd;
	logic        hit_any;
	logic [15:0] mode_word;
	logic [15:0] clock_word;
	logic [15:0] gain_word;
	logic [15:0] rsvd_word;
	logic [15:0] rd_word;

	always_comb
	begin
		req       = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
		word_idx  = wb_adr_i[ADDR_WIDTH-1:2];
		aligned   = (wb_adr_i[1:0] == 2'h0);
		hit_mode  = aligned & (word_idx == {2'h0, MODE_INDEX});
		hit_clock = aligned & (word_idx == {2'h0, CLOCK_INDEX}); // see R16
		hit_gain  = aligned & (word_idx == {2'h0, GAIN_INDEX}); // see R17
		hit_rsvd  = aligned & (word_idx == {2'h0, RSVD5_INDEX});
		hit_any   = hit_mode | hit_clock | hit_gain | hit_rsvd;
		wr_req    = req & wb_we_i & hit_any;
	end

	// ----------------------------------------
	// Configuration words
	// ----------------------------------------
	// Reserved mode bits are masked off so the stored word stays clean
	cfg_word_reg #(
		.RESET_VALUE (MODE_RESET),
		.WRITE_MASK  (MODE_WRITE_MASK)
	) u_mode (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.wr_i   (wr_req & hit_mode),
		.sel_i  (wb_sel_i[1:0]),
		.data_i (wb_dat_i[15:0]),
		.word_o (mode_word)
	);

	cfg_word_reg #(
		.RESET_VALUE (CLOCK_RESET),
		.WRITE_MASK  (CLOCK_WRITE_MASK) // see R10
	) u_clock (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.wr_i   (wr_req & hit_clock), // see R16
		.sel_i  (wb_sel_i[1:0]),
		.data_i (wb_dat_i[15:0]),
		.word_o (clock_word)
	);

	cfg_word_reg #(
		.RESET_VALUE (GAIN_RESET),
		.WRITE_MASK  (GAIN_WRITE_MASK)
	) u_gain (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.wr_i   (wr_req & hit_gain), // see R17
		.sel_i  (wb_sel_i[1:0]),
		.data_i (wb_dat_i[15:0]),
		.word_o (gain_word)
	);

	// Stored as written; the host is expected to keep it zero (see R9)
	cfg_word_reg #(
		.RESET_VALUE (RSVD5_RESET),
		.WRITE_MASK  (16'hffff)
	) u_rsvd (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.wr_i   (wr_req & hit_rsvd),
		.sel_i  (wb_sel_i[1:0]),
		.data_i (wb_dat_i[15:0]),
		.word_o (rsvd_word)
	);

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	logic        ack_reg;
	logic        ack_next;
	logic        err_reg;
	logic        err_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;

	always_comb
	begin
		unique case (1'b1)
			hit_mode:  rd_word = mode_word;
			hit_clock: rd_word = clock_word;
			hit_gain:  rd_word = gain_word;
			hit_rsvd:  rd_word = rsvd_word;
			default:   rd_word = 16'h0000;
		endcase
		ack_next = req & hit_any;
		// Unmapped or misaligned access ends with err, never hangs the master
		err_next = req & ~hit_any;
		dat_next = dat_reg;
		if (req & ~wb_we_i)
			dat_next = {16'h0000, rd_word};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= ack_next;
			err_reg <= err_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = dat_reg;

	// ----------------------------------------
	// Sample formatting and ready pin
	// ----------------------------------------
	logic [31:0] sample_reg;
	logic [31:0] sample_next;
	logic        rdy_reg;
	logic        rdy_next;
	logic        rdy_oe_n_reg;
	logic        rdy_oe_n_next;
	word_size_t  wsize;

	always_comb
	begin
		wsize = word_size_t'(mode_word[MODE_WSIZE_LSB +: 2]);
		unique case (wsize) // see R5
			WSIZE_16:      sample_next = {16'h0000, sample_i[23:8]};
			WSIZE_24:      sample_next = {8'h00, sample_i};
			WSIZE_32_PAD:  sample_next = {sample_i, 8'h00}; // see R6
			WSIZE_32_SIGN: sample_next = {{8{sample_i[23]}}, sample_i}; // see R6
		endcase
		// Ready is active low; idle either drives high or floats
		rdy_next      = ~data_avail_i;
		rdy_oe_n_next = ~data_avail_i & mode_word[MODE_FLOAT_BIT]; // see R8
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sample_reg   <= 32'h0000_0000;
			rdy_reg      <= 1'b1;
			rdy_oe_n_reg <= 1'b0;
		end
		else
		begin
			sample_reg   <= sample_next;
			rdy_reg      <= rdy_next;
			rdy_oe_n_reg <= rdy_oe_n_next;
		end
	end

	assign sample_word_o     = sample_reg;
	assign data_ready_out_o  = rdy_reg;
	assign data_ready_oe_n_o = rdy_oe_n_reg;

	// ----------------------------------------
	// Registered configuration outputs
	// ----------------------------------------
	logic [43:0] cfg_reg;
	logic [43:0] cfg_next;

	// Reset image uses the same packing, so it cannot drift from the words
	function automatic logic [43:0] pack_cfg(
		input logic [15:0] mode_w,
		input logic [15:0] clock_w,
		input logic [15:0] gain_w
	);
		logic [14:0] factor;
		// Ratio doubles per code step, 128 at code zero
		factor = 15'(15'h0080 << clock_w[CLOCK_OSR_LSB +: 3]); // see R13
		pack_cfg = {
			mode_w[MODE_REG_CRC_BIT],                   // see R1
			mode_w[MODE_RX_CRC_BIT],                    // see R2
			mode_w[MODE_CRC_SEL_BIT],                   // see R3
			mode_w[MODE_RST_FLAG_BIT],                  // see R4
			mode_w[MODE_WSIZE_LSB +: 2],                // see R5
			mode_w[MODE_TIMEOUT_BIT],                   // see R7
			clock_w[CLOCK_CHAN_LSB +: 4],               // see R11
			clock_w[CLOCK_SRC_BIT],                     // see R12
			clock_w[CLOCK_OSR_LSB +: 3],                // see R13
			factor,
			clock_w[CLOCK_PWR_LSB +: 2],                // see R14
			gain_w[3*GAIN_FIELD_STEP +: 3],             // see R15
			gain_w[2*GAIN_FIELD_STEP +: 3],
			gain_w[1*GAIN_FIELD_STEP +: 3],
			gain_w[0 +: 3]
		};
	endfunction : pack_cfg

	always_comb
	begin
		cfg_next = pack_cfg(mode_word, clock_word, gain_word);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cfg_reg <= pack_cfg(MODE_RESET, CLOCK_RESET, GAIN_RESET);
		else
			cfg_reg <= cfg_next;
	end

	assign reg_crc_on_o        = cfg_reg[43];
	assign rx_crc_on_o         = cfg_reg[42];
	assign crc_ansi_o          = cfg_reg[41];
	assign status_reset_flag_o = cfg_reg[40];
	assign word_size_select_o  = cfg_reg[39:38];
	assign timeout_on_o        = cfg_reg[37];
	assign chan3_on_o          = cfg_reg[36];
	assign chan2_on_o          = cfg_reg[35];
	assign chan1_on_o          = cfg_reg[34];
	assign chan0_on_o          = cfg_reg[33];
	assign ext_clock_sel_o     = cfg_reg[32];
	assign oversample_ratio_o  = cfg_reg[31:29];
	assign osr_factor_o        = cfg_reg[28:14];
	assign power_level_o       = cfg_reg[13:12];
	assign amp_gain_c3_o       = cfg_reg[11:9];
	assign amp_gain_c2_o       = cfg_reg[8:6];
	assign amp_gain_c1_o       = cfg_reg[5:3];
	assign amp_gain_c0_o       = cfg_reg[2:0];

endmodule : adc_config_register_bank

// ===== rtl/cfg_word_reg.sv
// Module: one 16-bit configuration word with write mask and reset value
`timescale 1ns/1ps
module cfg_word_reg #(
	parameter logic [15:0] RESET_VALUE = 16'h0000,
	parameter logic [15:0] WRITE_MASK  = 16'hffff
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Write port
	input  wire logic        wr_i,
	input  wire logic [1:0]  sel_i,
	input  wire logic [15:0] data_i,
	// Stored word
	output logic      [15:0] word_o
);

	logic [15:0] word_reg;
	logic [15:0] word_next;
	logic [15:0] lane_mask;

	// ----------------------------------------
	// Next value
	// ----------------------------------------
	always_comb
	begin
		lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}} & WRITE_MASK;
		word_next = word_reg;
		if (wr_i)
		begin
			// Read-only bits never take write data
			word_next = (word_reg & ~lane_mask) | (data_i & lane_mask);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			word_reg <= RESET_VALUE;
		else
			word_reg <= word_next;
	end

	assign word_o = word_reg;

endmodule : cfg_word_reg
